// file: common/odd_gray_pkg.sv
// Package: command codes, field layout and reset values of the mid odd gray table
package odd_gray_pkg;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int NUM_ENTRIES = 7;
  localparam int ENTRY_W = 8;
  localparam int PERIOD_W = 9;
  localparam logic [7:0] ODD_LEVEL12_PERIOD_OFS = 8'h22;
  localparam logic [7:0] ODD_LEVEL11_PERIOD_OFS = 8'h23;
  localparam logic [7:0] ODD_LEVEL10_PERIOD_OFS = 8'h24;
  localparam logic [7:0] ODD_LEVEL9_PERIOD_OFS = 8'h25;
  localparam logic [7:0] ODD_LEVEL8_PERIOD_OFS = 8'h26;
  localparam logic [7:0] ODD_LEVEL7_PERIOD_OFS = 8'h27;
  localparam logic [7:0] ODD_LEVEL6_PERIOD_OFS = 8'h28;
  localparam logic [7:0] ODD_LEVEL12_PERIOD_RST = 8'h53;
  localparam logic [7:0] ODD_LEVEL11_PERIOD_RST = 8'h39;
  localparam logic [7:0] ODD_LEVEL10_PERIOD_RST = 8'h27;
  localparam logic [7:0] ODD_LEVEL9_PERIOD_RST = 8'h1A;
  localparam logic [7:0] ODD_LEVEL8_PERIOD_RST = 8'h12;
  localparam logic [7:0] ODD_LEVEL7_PERIOD_RST = 8'h0C;
  localparam logic [7:0] ODD_LEVEL6_PERIOD_RST = 8'h08;
  localparam logic [2:0] GRAY_MODE_16 = 3'h1;
  typedef logic [ENTRY_W-1:0] entry_t;
  typedef entry_t [NUM_ENTRIES-1:0] entry_arr_t;
  // Index 0 is level 12, index 6 is level 6
  localparam entry_arr_t RESET_TABLE = {ODD_LEVEL6_PERIOD_RST, ODD_LEVEL7_PERIOD_RST,
    ODD_LEVEL8_PERIOD_RST, ODD_LEVEL9_PERIOD_RST, ODD_LEVEL10_PERIOD_RST,
    ODD_LEVEL11_PERIOD_RST, ODD_LEVEL12_PERIOD_RST};
endpackage

// file: common/odd_load_if.sv
// Interface: decoded load strobe between decoder and table
`timescale 1ns/100ps
interface odd_load_if;
  logic load;
  logic [2:0] index;
  logic [7:0] value;
  modport src (output load, output index, output value);
  modport dst (input load, input index, input value);
endinterface

// file: verilog/odd_cmd_decode.sv
// Command decoder: maps a command word onto a table entry load
`timescale 1ns/100ps
module odd_cmd_decode
  import odd_gray_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  odd_load_if.src load_bus
);
  logic [7:0] code;
  logic hit;
  assign code = cmd_word_i[CMD_MSB:CMD_LSB];
  ////////////////////////////////////////////////////////////////////////////
  // Codes 22h..28h select entries 0..6 in ascending order
  assign hit = (code >= ODD_LEVEL12_PERIOD_OFS) && (code <= ODD_LEVEL6_PERIOD_OFS);
  // Registered strobe keeps the table write path short
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_bus.load <= 1'b0;
      load_bus.index <= 3'h0;
      load_bus.value <= 8'h00;
    end else begin
      load_bus.load <= cmd_valid_i && hit;
      load_bus.index <= 3'(code - ODD_LEVEL12_PERIOD_OFS);
      load_bus.value <= cmd_word_i[DATA_MSB:DATA_LSB];
    end
  end
  // Only a matching code may produce a load
  property p_load_only_on_hit;
    @(posedge clk_i) disable iff (!rst_n_i)
    load_bus.load |-> $past(cmd_valid_i) && $past(hit);
  endproperty
  a_load_only_on_hit: assert property (p_load_only_on_hit) else $error("load without hit");
endmodule

// file: verilog/odd_gray_table_mid.sv
// Write-only odd gray period table for levels 12 down to 6
`timescale 1ns/100ps
module odd_gray_table_mid
  import odd_gray_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic CMD_VALID_I,
  input wire logic [15:0] CMD_WORD_I,
  input wire logic [2:0] GRAY_MODE_I,
  input wire logic [2:0] LEVEL_SEL_I,
  output logic [8:0] PERIOD_COUNT_O,
  output logic [7:0] ENTRY_VALUE_O
);
  logic rst_meta;
  logic rst_n;
  entry_t table_q [NUM_ENTRIES];
  odd_load_if load_bus ();
  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion is immediate
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Decoder of the host command word
  odd_cmd_decode u_decode (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .cmd_valid_i(CMD_VALID_I),
    .cmd_word_i(CMD_WORD_I),
    .load_bus(load_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Structure
  // Host word -> decoder (one flop) -> load strobe -> slot register.
  // A load therefore lands one edge after the word is taken, and shows on
  // the outputs one edge after that when its slot is selected.
  // Back-to-back words are fine: every word has its own strobe cycle.
  // Codes outside 22h..28h are dropped in the decoder without any answer.

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  // They are shared by the storage, the lookup and the checks below, so that
  // a slot number or a period count is worked out the same way everywhere.
  ////////////////////////////////////////////////////////////////////////////

  // Write select of one slot: the strobe must name exactly this slot
  function automatic logic entry_write(input logic load, input logic [2:0] index,
      input int unsigned slot);
    entry_write = load && (index == 3'(slot));
  endfunction

  // True when a select names one of the seven entries held here
  // Select 7 is spare and reads as an idle slot
  function automatic logic select_valid(input logic [2:0] sel);
    select_valid = sel < 3'(NUM_ENTRIES);
  endfunction

  // Value N drives N+1 gray clock periods; the extra bit keeps 256 exact
  // A count as narrow as the entry would wrap the largest value back to zero
  function automatic logic [PERIOD_W-1:0] period_of(input entry_t value);
    period_of = {1'b0, value} + 9'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Table storage, one register per odd level
  // Slot 0 is level 12 and slot 6 is level 6, in the order of the codes.
  // There is no read path towards the host: the entries only leave through
  // the timing generator lookup, so software cannot see what it loaded.
  // A load is taken whatever the display mode; keeping to the 16-level
  // mode is left to the host, and only a check below watches it.
  ////////////////////////////////////////////////////////////////////////////

  // One write select bit per slot, each driven from inside the loop
  logic [NUM_ENTRIES-1:0] wr_vec;

  for (genvar k = 0; k < NUM_ENTRIES; k++) begin : g_entry
    // Strobe decode for this slot only
    assign wr_vec[k] = entry_write(load_bus.load, load_bus.index, k);

    // Each slot restores its own default, so a reset rebuilds the whole table
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
        table_q[k] <= RESET_TABLE[k];
      end else if (wr_vec[k]) begin
        table_q[k] <= load_bus.value;
      end
    end

    // The first edge after release must still show the default
    property p_entry_reset;
      @(posedge CLOCK_I) disable iff (!rst_n)
      $rose(rst_n) |-> table_q[k] == RESET_TABLE[k];
    endproperty
    a_entry_reset: assert property (p_entry_reset) else $error("default lost");

    // Only a strobe addressed to this slot may change it
    property p_entry_holds;
      @(posedge CLOCK_I) disable iff (!rst_n)
      !wr_vec[k] |=> $stable(table_q[k]);
    endproperty
    a_entry_holds: assert property (p_entry_holds) else $error("entry changed");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the write select
  // They catch a decoder that opens two slots at once, or one with no strobe,
  // which the end-to-end tests would only see later as a wrong entry.
  ////////////////////////////////////////////////////////////////////////////

  // A strobe only ever names a slot that exists
  property p_index_in_range;
    @(posedge CLOCK_I) disable iff (!rst_n)
    load_bus.load |-> select_valid(load_bus.index);
  endproperty
  a_index_in_range: assert property (p_index_in_range) else $error("bad load index");

  // A strobe opens exactly one slot, and no slot opens without one
  property p_one_target;
    @(posedge CLOCK_I) disable iff (!rst_n)
    load_bus.load ? $onehot(wr_vec) : (wr_vec == '0);
  endproperty
  a_one_target: assert property (p_one_target) else $error("bad write select");

  ////////////////////////////////////////////////////////////////////////////
  // Timing generator lookup: raw value and N+1 count of the selected level
  // The lookup is one flop stage deep on purpose: the timing generator takes
  // the count straight from a register, at the cost of one edge of latency
  // after the select changes.
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      // Reset answer matches the spare select
      PERIOD_COUNT_O <= 9'h001;
      ENTRY_VALUE_O <= 8'h00;
    end else if (select_valid(LEVEL_SEL_I)) begin
      ENTRY_VALUE_O <= table_q[LEVEL_SEL_I];
      PERIOD_COUNT_O <= period_of(table_q[LEVEL_SEL_I]);
    end else begin
      // Spare select: value 0 and a single period
      ENTRY_VALUE_O <= 8'h00;
      PERIOD_COUNT_O <= 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the lookup
  // They tie both outputs to the stored entries and to each other, and pin
  // down the answer right after a reset release.
  ////////////////////////////////////////////////////////////////////////////

  // Count always one above the value
  property p_count_plus_one;
    @(posedge CLOCK_I) disable iff (!rst_n)
    PERIOD_COUNT_O == {1'b0, ENTRY_VALUE_O} + 9'h001;
  endproperty
  a_count_plus_one: assert property (p_count_plus_one) else $error("count not value+1");

  // The count never leaves the range of one to 256 periods
  property p_count_range;
    @(posedge CLOCK_I) disable iff (!rst_n)
    (PERIOD_COUNT_O != 9'h000) && (PERIOD_COUNT_O <= 9'h100);
  endproperty
  a_count_range: assert property (p_count_range) else $error("count out of range");

  // A valid select shows that slot's stored value one edge later
  property p_value_follows;
    @(posedge CLOCK_I) disable iff (!rst_n)
    rst_n && select_valid(LEVEL_SEL_I) |=> ENTRY_VALUE_O == $past(table_q[LEVEL_SEL_I]);
  endproperty
  a_value_follows: assert property (p_value_follows) else $error("wrong entry shown");

  // A spare select gives value 0 and a single period
  property p_idle_select;
    @(posedge CLOCK_I) disable iff (!rst_n)
    rst_n && !select_valid(LEVEL_SEL_I) |=> (ENTRY_VALUE_O == 8'h00) && (PERIOD_COUNT_O == 9'h001);
  endproperty
  a_idle_select: assert property (p_idle_select) else $error("spare select not idle");

  // Right after release the outputs still show the reset answer
  property p_release_quiet;
    @(posedge CLOCK_I) disable iff (!rst_n)
    $rose(rst_n) |-> (ENTRY_VALUE_O == 8'h00) && (PERIOD_COUNT_O == 9'h001);
  endproperty
  a_release_quiet: assert property (p_release_quiet) else $error("early output");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the write path
  // The mode check watches the host, not this block: a load in another mode
  // is still taken, and only this check reports it.
  ////////////////////////////////////////////////////////////////////////////

  // A load reaches the entry one cycle after the strobe
  property p_load_lands;
    @(posedge CLOCK_I) disable iff (!rst_n)
    load_bus.load |=> table_q[$past(load_bus.index)] == $past(load_bus.value);
  endproperty
  a_load_lands: assert property (p_load_lands) else $error("load lost");

  // Host loads only in 16-level mode (relied upon, not enforced)
  property p_mode_16;
    @(posedge CLOCK_I) disable iff (!rst_n)
    load_bus.load |-> $past(GRAY_MODE_I) == GRAY_MODE_16;
  endproperty
  a_mode_16: assert property (p_mode_16) else $error("load outside 16-level mode");
endmodule

// file: tb/host_model.sv
// Host model: sends load command words to the odd table
`timescale 1ns/100ps
module host_model
  import odd_gray_pkg::*;
(
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic [15:0] cmd_word_o,
  output logic [2:0] gray_mode_o
);
  // Loads only go out while the display sits in 16-level gray mode
  initial begin
    cmd_valid_o <= 1'b0;
    cmd_word_o <= 16'h0000;
    gray_mode_o <= GRAY_MODE_16;
  end
  // Call just after a rising edge; back-to-back calls keep valid high
  task send(input logic [7:0] code, input logic [7:0] val);
    cmd_valid_o <= 1'b1;
    cmd_word_o <= {code, val};
    @(posedge clk_i);
  endtask
  // A word on the bus without valid must never load
  task idle_word(input logic [7:0] code, input logic [7:0] val);
    cmd_valid_o <= 1'b0;
    cmd_word_o <= {code, val};
    @(posedge clk_i);
  endtask
  task stop();
    cmd_valid_o <= 1'b0;
  endtask
endmodule

// file: tb/tb.sv
// Testbench: default and load checks of the mid odd gray table
`timescale 1ns/100ps
module tb;
  import odd_gray_pkg::*;
  logic clk = 1'b0;
  logic arst_n;
  logic vld;
  logic [15:0] word;
  logic [2:0] mode;
  logic [2:0] sel = 3'h0;
  logic [8:0] cnt;
  logic [7:0] val;
  int err_count = 0;
  int num_checks = 0;
  entry_t exp_tab [7] = '{8'h00, 8'h7F, 8'hFF, 8'h01, 8'hFE, 8'h80, 8'h3C};
  host_model host_u (.clk_i(clk), .cmd_valid_o(vld), .cmd_word_o(word), .gray_mode_o(mode));
  odd_gray_table_mid dut_u (.CLOCK_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(vld),
    .CMD_WORD_I(word), .GRAY_MODE_I(mode), .LEVEL_SEL_I(sel), .PERIOD_COUNT_O(cnt),
    .ENTRY_VALUE_O(val));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task cmp(input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Outputs follow the select one edge late; sample well after it
  task look(input logic [2:0] s, input logic [7:0] e);
    sel <= s;
    repeat (2) @(posedge clk);
    #1;
    cmp({1'b0, e}, {1'b0, val});
    cmp({1'b0, e} + 9'h001, cnt);
    @(posedge clk);
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    // Driven low at time zero so the asynchronous reset really fires
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) look(3'(i), RESET_TABLE[i]);
    $display("test defaults done");
    // Back-to-back loads, boundary values, plus codes just outside the range
    for (int i = 0; i < 7; i++) host_u.send(8'h22 + 8'(i), exp_tab[i]);
    host_u.send(8'h29, 8'h55);
    host_u.send(8'h21, 8'hAA);
    host_u.idle_word(8'h22, 8'h99);
    host_u.stop();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) look(3'(i), exp_tab[i]);
    look(3'h7, 8'h00);
    $display("test loads done");
    // Second reset in mid-run must bring the defaults back
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) look(3'(i), RESET_TABLE[i]);
    $display("test second reset done");
    close_out();
  end
  // Hang guard
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
